// ==== console_ctrl_pkg.sv ====
// shared constants and carrier types for the console button and headphone control
package console_ctrl_pkg;
   // clock and timing
   localparam int unsigned CLK_HZ = 40_000_000;
   localparam int unsigned DEBOUNCE_MS = 10;
   localparam int unsigned HOLD_MS = 400;
   localparam int unsigned BOOT_STEP_MS = 250;
   localparam int unsigned DEBOUNCE_CYC = CLK_HZ / 1000 * DEBOUNCE_MS;
   localparam int unsigned HOLD_CYC = CLK_HZ / 1000 * HOLD_MS;
   localparam int unsigned BOOT_STEP_CYC = CLK_HZ / 1000 * BOOT_STEP_MS;
   localparam int unsigned CNT_W = 25;

   // register byte offsets
   localparam logic [3:0] CFG_OFS = 4'h0;
   localparam logic [3:0] STAT_OFS = 4'h4;
   localparam logic [3:0] POT_OFS = 4'h8;

   // control register fields
   localparam int unsigned CFG_MAIN_MODE_LSB = 0;
   localparam int unsigned CFG_TB_HYBRID = 2;
   localparam int unsigned CFG_HP_BALANCE = 3;
   localparam int unsigned CFG_REVERSE = 4;
   localparam int unsigned CFG_FULL_MUTE = 5;
   localparam int unsigned CFG_PRODUCTION = 6;
   localparam logic [7:0] CFG_RESET = 8'h00;

   // status register fields
   localparam int unsigned STAT_MAIN_ON = 0;
   localparam int unsigned STAT_TB_ON = 1;
   localparam int unsigned STAT_MAIN_LATCH = 2;
   localparam int unsigned STAT_TB_LATCH = 3;
   localparam int unsigned STAT_BOOTING = 4;
   localparam int unsigned STAT_MAIN_BTN = 5;
   localparam int unsigned STAT_TB_BTN = 6;

   // headphone attenuation
   localparam int unsigned POT_W = 8;
   localparam logic [7:0] POT_CCW_END = 8'h00;
   localparam logic [7:0] POT_CW_END = 8'hff;
   localparam logic [7:0] POT_CENTER = 8'h80;
   localparam logic [7:0] ATT_MIN_DB = 8'h28;

   typedef enum logic [1:0] {
      MAIN_PUSH_MUTE = 2'b00,
      MAIN_PUSH_TALK = 2'b01,
      MAIN_ALTERNATE = 2'b10,
      MAIN_HYBRID = 2'b11
   } main_mode_t;

   typedef enum logic [1:0] {
      BOOT_RED = 2'b00,
      BOOT_GREEN = 2'b01,
      BOOT_TALK = 2'b10,
      BOOT_RUN = 2'b11
   } boot_t;

   typedef struct packed {
      logic [1:0] sync;
      logic db;
      logic [CNT_W-1:0] deb_cnt;
      logic [CNT_W-1:0] hold_cnt;
      logic latch;
   } btn_t;

   typedef struct packed {
      logic led_red;
      logic led_green;
      logic led_tb;
      logic main_on;
      logic tb_on;
   } panel_t;

   typedef struct packed {
      logic [7:0] att_l;
      logic [7:0] att_r;
      logic mute_l;
      logic mute_r;
   } phones_t;

   typedef struct packed {
      logic waitreq;
      logic [31:0] rdata;
   } bus_t;

   typedef struct packed {
      boot_t boot;
      logic [CNT_W-1:0] boot_cnt;
      btn_t [1:0] btn;
      logic [7:0] cfg;
      logic [1:0][POT_W-1:0] pot_l;
      logic [1:0][POT_W-1:0] pot_r;
      panel_t panel;
      phones_t phones;
      bus_t bus;
   } state_t;
endpackage : console_ctrl_pkg

// ==== console_ctrl.sv ====
// pushbutton, indicator and headphone level control for the announcer console
//
// Added by the designer: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/1ps

module console_ctrl #(
   parameter int unsigned DEBOUNCE_CYCLES = console_ctrl_pkg::DEBOUNCE_CYC,
   parameter int unsigned HOLD_CYCLES = console_ctrl_pkg::HOLD_CYC,
   parameter int unsigned BOOT_CYCLES = console_ctrl_pkg::BOOT_STEP_CYC
) (
   input wire logic ref_clk,
   input wire logic sys_rst,
   // front panel
   input wire logic main_mute_button,
   input wire logic talkback_button,
   input wire logic [console_ctrl_pkg::POT_W-1:0] pot_left,
   input wire logic [console_ctrl_pkg::POT_W-1:0] pot_right,
   output logic main_active,
   output logic talkback_active,
   output logic led_main_red,
   output logic led_main_green,
   output logic led_talkback_green,
   output logic [7:0] hp_left_att,
   output logic [7:0] hp_right_att,
   output logic hp_left_mute,
   output logic hp_right_mute,
   // register bus
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest
);

   localparam logic [console_ctrl_pkg::CNT_W-1:0] DEB_LIM =
      console_ctrl_pkg::CNT_W'(DEBOUNCE_CYCLES);
   localparam logic [console_ctrl_pkg::CNT_W-1:0] HOLD_LIM =
      console_ctrl_pkg::CNT_W'(HOLD_CYCLES);
   localparam logic [console_ctrl_pkg::CNT_W-1:0] BOOT_LIM =
      console_ctrl_pkg::CNT_W'(BOOT_CYCLES);

   console_ctrl_pkg::state_t st_r;
   console_ctrl_pkg::state_t st_nxt;

   // span of 0..255 onto 0..39 dB of attenuation
   function automatic logic [7:0] att_span(input logic [7:0] d);
      logic [15:0] p;
      p = 16'(d) * 16'(console_ctrl_pkg::ATT_MIN_DB);
      return p[15:8];
   endfunction : att_span

   // add two attenuations, saturating at the minimum level
   function automatic logic [7:0] att_sum(input logic [7:0] a, input logic [7:0] b);
      logic [8:0] s;
      s = {1'b0, a} + {1'b0, b};
      if (s >= {1'b0, console_ctrl_pkg::ATT_MIN_DB}) begin
         return console_ctrl_pkg::ATT_MIN_DB;
      end
      return s[7:0];
   endfunction : att_sum

   logic [1:0] btn_in;
   logic [1:0] db_nxt;
   logic [1:0] rise;
   logic [1:0] fall;
   logic [1:0] tap;
   logic booting;
   logic onair;
   logic main_raw;
   logic tb_now;
   logic main_now;
   console_ctrl_pkg::main_mode_t main_mode;
   logic [7:0] pl;
   logic [7:0] pr;
   logic [7:0] att_a;
   logic [7:0] att_b;
   logic mute_a;
   logic mute_b;
   logic [7:0] dev;
   logic bus_req;
   logic [31:0] rd_val;

   assign btn_in = {talkback_button, main_mute_button};

   // next state of the whole block
   always_comb begin
      st_nxt = st_r;
      booting = (st_r.boot != console_ctrl_pkg::BOOT_RUN);
      onair = ~st_r.cfg[console_ctrl_pkg::CFG_PRODUCTION];
      main_mode = console_ctrl_pkg::main_mode_t'(
         st_r.cfg[console_ctrl_pkg::CFG_MAIN_MODE_LSB +: 2]);

      // buttons: two-flop sync, debounce, press timing
      for (int i = 0; i < 2; i++) begin
         st_nxt.btn[i].sync = {st_r.btn[i].sync[0], btn_in[i]};
         db_nxt[i] = st_r.btn[i].db;
         if (st_r.btn[i].sync[1] == st_r.btn[i].db) begin
            st_nxt.btn[i].deb_cnt = '0;
         end else if (st_r.btn[i].deb_cnt >= DEB_LIM - 1'b1) begin
            st_nxt.btn[i].deb_cnt = '0;
            db_nxt[i] = st_r.btn[i].sync[1];
         end else begin
            st_nxt.btn[i].deb_cnt = st_r.btn[i].deb_cnt + 1'b1;
         end
         st_nxt.btn[i].db = db_nxt[i];
         rise[i] = db_nxt[i] & ~st_r.btn[i].db;
         fall[i] = ~db_nxt[i] & st_r.btn[i].db;
         tap[i] = fall[i] & (st_r.btn[i].hold_cnt < HOLD_LIM);
         if (rise[i]) begin
            st_nxt.btn[i].hold_cnt = '0;
         end else if (st_r.btn[i].db && st_r.btn[i].hold_cnt < HOLD_LIM) begin
            st_nxt.btn[i].hold_cnt = st_r.btn[i].hold_cnt + 1'b1;
         end
      end

      // main latch: toggle per press, or tap/hold in hybrid
      if (booting) begin
         st_nxt.btn[0].latch = 1'b0;
      end else if (main_mode == console_ctrl_pkg::MAIN_ALTERNATE && rise[0]) begin
         st_nxt.btn[0].latch = ~st_r.btn[0].latch;
      end else if (main_mode == console_ctrl_pkg::MAIN_HYBRID && fall[0]) begin
         st_nxt.btn[0].latch = tap[0] ? ~st_r.btn[0].latch : 1'b0;
      end

      // talkback latch in hybrid mode only
      if (booting || !st_r.cfg[console_ctrl_pkg::CFG_TB_HYBRID]) begin
         st_nxt.btn[1].latch = 1'b0;
      end else if (fall[1]) begin
         st_nxt.btn[1].latch = tap[1] ? ~st_r.btn[1].latch : 1'b0;
      end

      // output states from button modes
      unique case (main_mode)
         console_ctrl_pkg::MAIN_PUSH_MUTE: main_raw = ~db_nxt[0];
         console_ctrl_pkg::MAIN_PUSH_TALK: main_raw = db_nxt[0];
         console_ctrl_pkg::MAIN_ALTERNATE: main_raw = st_nxt.btn[0].latch;
         console_ctrl_pkg::MAIN_HYBRID: main_raw = db_nxt[0] | st_nxt.btn[0].latch;
      endcase
      if (st_r.cfg[console_ctrl_pkg::CFG_TB_HYBRID]) begin
         tb_now = db_nxt[1] | st_nxt.btn[1].latch;
      end else begin
         tb_now = db_nxt[1];
      end
      tb_now = tb_now & ~booting;
      // latch is kept untouched, so main resumes when talkback ends
      main_now = main_raw & ~booting & ~(onair & tb_now);
      st_nxt.panel.main_on = main_now;
      st_nxt.panel.tb_on = tb_now;

      // indicators and boot sequence
      if (booting) begin
         if (st_r.boot_cnt >= BOOT_LIM - 1'b1) begin
            st_nxt.boot_cnt = '0;
            st_nxt.boot = console_ctrl_pkg::boot_t'(st_r.boot + 2'h1);
         end else begin
            st_nxt.boot_cnt = st_r.boot_cnt + 1'b1;
         end
      end
      unique case (st_nxt.boot)
         console_ctrl_pkg::BOOT_RED: st_nxt.panel[4:2] = 3'h4;
         console_ctrl_pkg::BOOT_GREEN: st_nxt.panel[4:2] = 3'h2;
         console_ctrl_pkg::BOOT_TALK: st_nxt.panel[4:2] = 3'h1;
         console_ctrl_pkg::BOOT_RUN: begin
            st_nxt.panel.led_red = onair & ~main_now;
            st_nxt.panel.led_green = main_now;
            st_nxt.panel.led_tb = tb_now;
         end
      endcase

      // control positions: two-flop sync; channel a is left in normal orientation
      st_nxt.pot_l = {st_r.pot_l[0], pot_left};
      st_nxt.pot_r = {st_r.pot_r[0], pot_right};
      pl = st_r.pot_l[1];
      pr = st_r.pot_r[1];
      mute_a = 1'b0;
      mute_b = 1'b0;
      dev = 8'h00;
      if (!st_r.cfg[console_ctrl_pkg::CFG_HP_BALANCE]) begin
         att_a = att_span(~pl);
         att_b = att_span(~pr);
         if (pl == console_ctrl_pkg::POT_CCW_END) begin
            att_a = console_ctrl_pkg::ATT_MIN_DB;
            mute_a = st_r.cfg[console_ctrl_pkg::CFG_FULL_MUTE];
         end
         if (pr == console_ctrl_pkg::POT_CCW_END) begin
            att_b = console_ctrl_pkg::ATT_MIN_DB;
            mute_b = st_r.cfg[console_ctrl_pkg::CFG_FULL_MUTE];
         end
      end else begin
         // level from left control, balance from right control
         att_a = att_span(~pl);
         att_b = att_a;
         if (pr < console_ctrl_pkg::POT_CENTER) begin
            dev = console_ctrl_pkg::POT_CENTER - pr;
            att_b = att_sum(att_a, att_span({dev[6:0], 1'b0}));
         end else begin
            dev = pr - console_ctrl_pkg::POT_CENTER;
            att_a = att_sum(att_a, att_span({dev[6:0], 1'b0}));
         end
         if (pr == console_ctrl_pkg::POT_CCW_END) begin
            att_b = console_ctrl_pkg::ATT_MIN_DB;
            mute_b = st_r.cfg[console_ctrl_pkg::CFG_FULL_MUTE];
         end
         if (pr == console_ctrl_pkg::POT_CW_END) begin
            att_a = console_ctrl_pkg::ATT_MIN_DB;
            mute_a = st_r.cfg[console_ctrl_pkg::CFG_FULL_MUTE];
         end
         if (pl == console_ctrl_pkg::POT_CCW_END) begin
            att_a = console_ctrl_pkg::ATT_MIN_DB;
            att_b = console_ctrl_pkg::ATT_MIN_DB;
            mute_a = st_r.cfg[console_ctrl_pkg::CFG_FULL_MUTE];
            mute_b = st_r.cfg[console_ctrl_pkg::CFG_FULL_MUTE];
         end
      end
      // orientation swap
      if (st_r.cfg[console_ctrl_pkg::CFG_REVERSE]) begin
         st_nxt.phones = {att_b, att_a, mute_b, mute_a};
      end else begin
         st_nxt.phones = {att_a, att_b, mute_a, mute_b};
      end

      // register bus: one wait cycle, then the request is taken
      bus_req = avs_read | avs_write;
      rd_val = 32'h0000_0000;
      unique case (avs_address)
         console_ctrl_pkg::CFG_OFS: rd_val[7:0] = st_r.cfg;
         console_ctrl_pkg::STAT_OFS: begin
            rd_val[console_ctrl_pkg::STAT_MAIN_ON] = st_r.panel.main_on;
            rd_val[console_ctrl_pkg::STAT_TB_ON] = st_r.panel.tb_on;
            rd_val[console_ctrl_pkg::STAT_MAIN_LATCH] = st_r.btn[0].latch;
            rd_val[console_ctrl_pkg::STAT_TB_LATCH] = st_r.btn[1].latch;
            rd_val[console_ctrl_pkg::STAT_BOOTING] = booting;
            rd_val[console_ctrl_pkg::STAT_MAIN_BTN] = st_r.btn[0].db;
            rd_val[console_ctrl_pkg::STAT_TB_BTN] = st_r.btn[1].db;
         end
         console_ctrl_pkg::POT_OFS: rd_val[15:0] = {pr, pl};
         default: rd_val = 32'h0000_0000; // unmapped reads as zero
      endcase
      if (bus_req && st_r.bus.waitreq) begin
         st_nxt.bus.waitreq = 1'b0;
         st_nxt.bus.rdata = avs_read ? rd_val : 32'h0000_0000;
      end else begin
         st_nxt.bus.waitreq = 1'b1;
      end
      if (avs_write && !st_r.bus.waitreq && avs_address == console_ctrl_pkg::CFG_OFS &&
          avs_byteenable[0]) begin
         st_nxt.cfg = avs_writedata[7:0];
      end
   end

   // single state register
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         st_r <= '0;
         st_r.boot <= console_ctrl_pkg::BOOT_RED;
         st_r.panel.led_red <= 1'b1;
         st_r.cfg <= console_ctrl_pkg::CFG_RESET;
         st_r.bus.waitreq <= 1'b1;
      end else begin
         st_r <= st_nxt;
      end
   end

   // outputs straight from the state register
   assign main_active = st_r.panel.main_on;
   assign talkback_active = st_r.panel.tb_on;
   assign led_main_red = st_r.panel.led_red;
   assign led_main_green = st_r.panel.led_green;
   assign led_talkback_green = st_r.panel.led_tb;
   assign hp_left_att = st_r.phones.att_l;
   assign hp_right_att = st_r.phones.att_r;
   assign hp_left_mute = st_r.phones.mute_l;
   assign hp_right_mute = st_r.phones.mute_r;
   assign avs_readdata = st_r.bus.rdata;
   assign avs_waitrequest = st_r.bus.waitreq;

endmodule : console_ctrl

// ==== console_ctrl_monitor.sv ====
// port-level checks for the console control block
`timescale 1ns/1ps
module console_ctrl_monitor #(
   parameter int unsigned BOOT_CYCLES = 8
) (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic main_mute_button,
   input wire logic talkback_button,
   input wire logic [7:0] pot_left,
   input logic main_active,
   input logic talkback_active,
   input logic led_main_red,
   input logic led_main_green,
   input logic led_talkback_green,
   input logic [7:0] hp_left_att,
   input logic hp_left_mute,
   input logic hp_right_mute,
   input wire logic [3:0] avs_address,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   input logic avs_waitrequest
);
   logic [15:0] cnt_r;
   logic [7:0] cfg_r;
   logic [3:0] age_r, lo_m_r, hi_m_r, lo_t_r, hi_t_r, pz_r;
   logic run, cfg_wr;
   assign run = cnt_r > 16'(3 * BOOT_CYCLES + 3);
   assign cfg_wr = avs_write && !avs_waitrequest && avs_address == 4'h0 && avs_byteenable[0];

   // saturating count of cycles a condition has held
   function automatic logic [3:0] sat(input logic [3:0] c, input logic hit);
      return hit ? (c == 4'hf ? c : c + 4'h1) : 4'h0;
   endfunction : sat

   // time since reset, config shadow, stable-level counters
   always_ff @(posedge ref_clk) begin
      cnt_r <= sys_rst ? 16'h0 : (cnt_r == 16'hffff ? cnt_r : cnt_r + 16'h1);
      cfg_r <= sys_rst ? console_ctrl_pkg::CFG_RESET : (cfg_wr ? avs_writedata[7:0] : cfg_r);
      age_r <= sys_rst ? 4'h0 : sat(age_r, !cfg_wr);
      lo_m_r <= sys_rst ? 4'h0 : sat(lo_m_r, !main_mute_button);
      hi_m_r <= sys_rst ? 4'h0 : sat(hi_m_r, main_mute_button);
      lo_t_r <= sys_rst ? 4'h0 : sat(lo_t_r, !talkback_button);
      hi_t_r <= sys_rst ? 4'h0 : sat(hi_t_r, talkback_button);
      pz_r <= sys_rst ? 4'h0 : sat(pz_r, pot_left == 8'h00);
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (sys_rst);

   boot_start_a: assert property ($fell(sys_rst) |-> led_main_red && !led_main_green
      && !led_talkback_green && !main_active) else $error("boot does not start on red light");
   boot_green_a: assert property (cnt_r >= BOOT_CYCLES + 2 && cnt_r <= 2 * BOOT_CYCLES - 3
      |-> led_main_green && !led_main_red) else $error("second boot step not green");
   green_main_a: assert property (run |-> led_main_green == main_active)
      else $error("green main light differs from main output");
   tb_light_a: assert property (run |-> led_talkback_green == talkback_active)
      else $error("talkback light differs from talkback output");
   red_onair_a: assert property (run && age_r > 4'h1 && !cfg_r[6]
      |-> led_main_red == !main_active) else $error("red light wrong in on-air mode");
   red_prod_a: assert property (run && age_r > 4'h1 && cfg_r[6] |-> !led_main_red)
      else $error("red light lit in production mode");
   main_interlock_a: assert property (run && age_r > 4'h1 && !cfg_r[6] && talkback_active
      |-> !main_active) else $error("main active during talkback on air");
   push_mute_a: assert property (run && age_r > 4'h3 && cfg_r[1:0] == 2'b00 && lo_m_r > 4'h9
      && !talkback_active && !$past(talkback_active) |-> main_active) else $error("main not resting active");
   push_talk_a: assert property (run && age_r > 4'h3 && cfg_r[1:0] == 2'b01 && hi_m_r > 4'h9
      |-> main_active || talkback_active) else $error("main not active while held");
   tb_rest_a: assert property (run && age_r > 4'h3 && !cfg_r[2] && lo_t_r > 4'h9
      |-> !talkback_active) else $error("talkback active with button up");
   tb_held_a: assert property (run && age_r > 4'h3 && !cfg_r[2] && hi_t_r > 4'h9
      |-> talkback_active) else $error("talkback not active while held");
   hp_floor_a: assert property (run && age_r > 4'h3 && pz_r > 4'h4 && cfg_r[5:3] == 3'b000
      |-> hp_left_att == console_ctrl_pkg::ATT_MIN_DB && !hp_left_mute) else $error("floor not 40 dB");
   hp_mute_a: assert property (run && age_r > 4'h3 && pz_r > 4'h4 && cfg_r[5] && !cfg_r[3]
      |-> (cfg_r[4] ? hp_right_mute : hp_left_mute)) else $error("end stop does not mute channel");
   hp_bal_mute_a: assert property (run && age_r > 4'h3 && pz_r > 4'h4 && cfg_r[5] && cfg_r[3]
      |-> hp_left_mute && hp_right_mute) else $error("level end does not mute both");

   // main scenarios reached
   cover property (talkback_active && !main_active && !cfg_r[6]);
   cover property (main_active && cfg_r[1:0] == 2'b11);
   cover property (hp_left_mute && hp_right_mute);
endmodule : console_ctrl_monitor

// ==== panel_model.sv ====
// front-panel pushbuttons with optional contact chatter
`timescale 1ns/1ps
module panel_model (
   input wire logic ref_clk,
   input wire logic main_req,
   input wire logic tb_req,
   input wire logic chatter,
   output logic main_mute_button,
   output logic talkback_button
);
   logic ph_r = 1'b0;
   // chatter flips the contacts every cycle, shorter than any debounce
   always_ff @(posedge ref_clk) ph_r <= ~ph_r;
   assign main_mute_button = main_req ^ (chatter & ph_r);
   assign talkback_button = tb_req ^ (chatter & ph_r);
endmodule : panel_model

// ==== console_ctrl_tb.sv ====
// self-checking bench for the console control block
`timescale 1ns/1ps
module console_ctrl_tb;
   localparam int unsigned BOOT = 8;
   logic ref_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic main_req = 1'b0, tb_req = 1'b0, chatter = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
   logic main_mute_button, talkback_button, main_active, talkback_active, avs_waitrequest;
   logic led_main_red, led_main_green, led_talkback_green, hp_left_mute, hp_right_mute;
   logic [7:0] pot_left = 8'h80, pot_right = 8'h80, hp_left_att, hp_right_att;
   logic [3:0] avs_address = 4'h0;
   logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
   int fails = 0, n_checks = 0, cycles = 0;
   // cfg, left pot, right pot, left att, right att, {left mute, right mute}
   logic [47:0] pot_tab [9] = '{48'h0000ff280000, 48'h1000ff002800,
      48'h2000ff000002, 48'h08ff00002800, 48'h18ff00280000,
      48'h280080000003, 48'h28ffff000002, 48'h008080131300,
      48'h08ff40001400};

   console_ctrl #(.DEBOUNCE_CYCLES(4), .HOLD_CYCLES(20), .BOOT_CYCLES(BOOT)) console_ctrl_i (
      .ref_clk, .sys_rst, .main_mute_button, .talkback_button, .pot_left, .pot_right,
      .main_active, .talkback_active, .led_main_red, .led_main_green, .led_talkback_green,
      .hp_left_att, .hp_right_att, .hp_left_mute, .hp_right_mute, .avs_address, .avs_read,
      .avs_write, .avs_writedata, .avs_byteenable(4'hf), .avs_readdata, .avs_waitrequest);
   panel_model panel_model_i (.ref_clk, .main_req, .tb_req, .chatter, .main_mute_button,
      .talkback_button);

   initial forever #12.5 ref_clk = ~ref_clk;

   task automatic wait_cyc(input int n);
      repeat (n) @(posedge ref_clk);
   endtask : wait_cyc

   // one bus transfer, held until waitrequest is seen low
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask : bus

   task automatic btn(input logic m, input logic t, input int n);
      main_req <= m;
      tb_req <= t;
      wait_cyc(n);
   endtask : btn

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fails++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   task automatic summarize;
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : summarize

   // hang guard
   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         fails++;
         summarize();
      end
   end

   initial begin
      repeat (16) @(posedge ref_clk);
      sys_rst <= 1'b0;
      @(posedge ref_clk);
      chk(led_main_red, 1'b1);
      wait_cyc(BOOT + 2);
      chk(led_main_green, 1'b1);
      wait_cyc(BOOT);
      chk(led_talkback_green, 1'b1);
      wait_cyc(BOOT + 4);
      chk({main_active, led_main_green, led_main_red}, 3'b110);
      bus(1'b0, 4'h4, 32'h0);
      chk(rd, 32'h00000001);
      bus(1'b0, 4'hc, 32'h0);
      chk(rd, 32'h00000000);
      btn(1'b1, 1'b0, 12);
      chk({main_active, led_main_red}, 2'b01);
      btn(1'b0, 1'b0, 12);
      chatter <= 1'b1;
      wait_cyc(3);
      chatter <= 1'b0;
      wait_cyc(10);
      chk(main_active, 1'b1);
      bus(1'b1, 4'h0, 32'h1);
      wait_cyc(2);
      chk(main_active, 1'b0);
      btn(1'b1, 1'b0, 12);
      chk(main_active, 1'b1);
      btn(1'b0, 1'b0, 12);
      bus(1'b1, 4'h0, 32'h2);
      wait_cyc(2);
      chk(main_active, 1'b0);
      btn(1'b1, 1'b0, 10);
      btn(1'b0, 1'b0, 12);
      chk(main_active, 1'b1);
      btn(1'b0, 1'b1, 12);
      chk({main_active, talkback_active, led_talkback_green}, 3'b011);
      btn(1'b0, 1'b0, 12);
      chk({main_active, talkback_active}, 2'b10);
      bus(1'b1, 4'h0, 32'h42);
      btn(1'b0, 1'b1, 12);
      chk({main_active, talkback_active, led_main_red}, 3'b110);
      btn(1'b1, 1'b0, 10);
      btn(1'b0, 1'b0, 12);
      chk(main_active, 1'b0);
      bus(1'b1, 4'h0, 32'h3);
      btn(1'b1, 1'b0, 10);
      btn(1'b0, 1'b0, 12);
      chk(main_active, 1'b1);
      btn(1'b1, 1'b0, 40);
      chk(main_active, 1'b1);
      btn(1'b0, 1'b0, 12);
      chk(main_active, 1'b0);
      bus(1'b1, 4'h0, 32'h4);
      btn(1'b0, 1'b1, 10);
      btn(1'b0, 1'b0, 12);
      chk({talkback_active, main_active}, 2'b10);
      btn(1'b0, 1'b1, 10);
      btn(1'b0, 1'b0, 12);
      chk(talkback_active, 1'b0);
      for (int i = 0; i < 9; i++) begin
         bus(1'b1, 4'h0, {24'h0, pot_tab[i][47:40]});
         pot_left <= pot_tab[i][39:32];
         pot_right <= pot_tab[i][31:24];
         wait_cyc(6);
         chk({hp_left_mute, hp_right_mute}, pot_tab[i][1:0]);
         if (!pot_tab[i][1]) chk(hp_left_att, pot_tab[i][23:16]);
         if (!pot_tab[i][0]) chk(hp_right_att, pot_tab[i][15:8]);
      end
      summarize();
   end
endmodule : console_ctrl_tb

bind console_ctrl console_ctrl_monitor #(.BOOT_CYCLES(BOOT_CYCLES)) console_ctrl_monitor_i (
   .ref_clk, .sys_rst, .main_mute_button, .talkback_button, .pot_left, .main_active,
   .talkback_active, .led_main_red, .led_main_green, .led_talkback_green, .hp_left_att,
   .hp_left_mute, .hp_right_mute, .avs_address, .avs_write, .avs_writedata, .avs_byteenable,
   .avs_waitrequest);
